// file: pscp_host.sv
// host model: request pin, config_clock and serial data
// assumes pulled-up status and load-complete wires fed back to it
`timescale 1ns/1ps
module pscp_host (
  input  wire logic i_status,
  input  wire logic i_done,
  output logic      o_req_n,
  output logic      o_cclk,
  output logic      o_data
);
  initial
  begin
    o_req_n = 1'b1;
    o_cclk  = 1'b0;
    o_data  = 1'b0;
  end
  // clock parks at its last level; no idle edges reach the port
  task automatic send_byte(input logic [7:0] b, input int p);
    for (int i = 0; i < 8; i++)
    begin
      o_cclk = 1'b0;
      o_data = b[i];
      #24 o_cclk = 1'b1;
      #24;
      if (i == 4)
        #(p);
    end
  endtask
  task automatic clk(input int n);
    repeat (n)
    begin
      o_cclk = 1'b0;
      #24 o_cclk = 1'b1;
      #24;
    end
  endtask
  task automatic pulse_req();
    o_req_n = 1'b0;
    #600 o_req_n = 1'b1;
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 2000 && i_status !== 1'b1; i++)
      #4;
  endtask
endmodule

// file: pscp_pkg.sv
// constants and types of the passive serial configuration port
// assumes a 250 MHz core clock; pins are synchronised in the top module
package pscp_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned RESTART_TMO_NS  = 230000;
  localparam int unsigned INIT_MIN_NS     = 300000;
  localparam int unsigned POR_DELAY_NS    = 50000000;
  // longest time rounds down, least time rounds up
  localparam int unsigned RESTART_CYC     = RESTART_TMO_NS / CLK_PERIOD_NS;
  localparam int unsigned INIT_CYC        =
    (INIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POR_CYC         =
    (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STREAM_BITS     = 32'h0001_0000;
  localparam int unsigned SYNC_W          = 7;
  localparam logic [1:0]  DONE_FALLS      = 2'h2;
  localparam logic [2:0]  BYTE_LAST_BIT   = 3'h7;
  localparam int unsigned CNT_W           = 32;
  localparam logic [31:0] CNT_ONE         = 32'h0000_0001;

  // pin positions inside the synchroniser vector
  localparam int unsigned PIN_REQ_N       = 0;
  localparam int unsigned PIN_CCLK        = 1;
  localparam int unsigned PIN_DATA        = 2;
  localparam int unsigned PIN_STATUS      = 3;
  localparam int unsigned PIN_DONE        = 4;
  localparam int unsigned PIN_AUTO        = 5;
  localparam int unsigned PIN_DUAL        = 6;

  typedef enum logic [2:0] {
    PSCP_POR,
    PSCP_RESET,
    PSCP_HOLD,
    PSCP_LOAD,
    PSCP_ERROR,
    PSCP_DONE_WAIT,
    PSCP_INIT,
    PSCP_USER
  } pscp_state_t;
endpackage

// file: pscp_port.sv
// passive serial configuration port, device end
// assumes open-drain status, load-complete and init-complete lines with
// external pull-ups; config_clock comes from the host and is oversampled
`timescale 1ns/1ps
module pscp_port #(
  parameter logic [31:0] POR_CYCLES     = pscp_pkg::POR_CYC,
  parameter logic [31:0] RESTART_CYCLES = pscp_pkg::RESTART_CYC,
  parameter logic [31:0] INIT_CYCLES    = pscp_pkg::INIT_CYC,
  parameter logic [31:0] STREAM_LEN     = pscp_pkg::STREAM_BITS
) (
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  input  wire logic       i_cfg_request_n,
  input  wire logic       i_config_clock,
  input  wire logic       i_data_in,
  input  wire logic       i_status_in,
  input  wire logic       i_done_in,
  input  wire logic       i_auto_restart,
  input  wire logic       i_dual_purpose,
  input  wire logic       i_cfg_error,
  input  wire logic       i_user_data_out,
  output logic            o_status_out,
  output logic            o_status_oe,
  output logic            o_done_out,
  output logic            o_done_oe,
  output logic            o_init_out,
  output logic            o_init_oe,
  output logic            o_data_out,
  output logic            o_data_oe,
  output logic [7:0]      o_cfg_byte,
  output logic            o_cfg_byte_valid,
  output logic            o_weak_pullup_en,
  output logic            o_user_mode
);
  logic                         rst_meta;
  logic                         rst_n;
  logic [pscp_pkg::SYNC_W-1:0]  pins;
  logic                         cclk_prev;
  logic                         cclk_rise;
  logic                         cclk_fall;
  logic                         req_n;
  logic                         status_hi;
  logic                         done_hi;

  pscp_pkg::pscp_state_t        state;
  pscp_pkg::pscp_state_t        next_state;
  logic [pscp_pkg::CNT_W-1:0]   timer;
  logic [pscp_pkg::CNT_W-1:0]   next_timer;
  logic [pscp_pkg::CNT_W-1:0]   bits;
  logic [pscp_pkg::CNT_W-1:0]   next_bits;
  logic [7:0]                   shreg;
  logic [7:0]                   next_shreg;
  logic [2:0]                   bit_pos;
  logic [2:0]                   next_bit_pos;
  logic [1:0]                   falls;
  logic [1:0]                   next_falls;
  logic [7:0]                   next_cfg_byte;
  logic                         next_cfg_byte_valid;
  logic                         next_status_oe;
  logic                         next_done_oe;
  logic                         next_init_oe;
  logic                         next_data_oe;
  logic                         next_user_mode;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  pscp_sync #(
    .W (pscp_pkg::SYNC_W)
  ) u_sync (
    .i_clk   (i_mclk),
    .i_rst_n (rst_n),
    .i_async ({i_dual_purpose, i_auto_restart, i_done_in, i_status_in,
               i_data_in, i_config_clock, i_cfg_request_n}),
    .o_sync  (pins)
  );

  assign req_n     = pins[pscp_pkg::PIN_REQ_N];
  assign status_hi = pins[pscp_pkg::PIN_STATUS];
  assign done_hi   = pins[pscp_pkg::PIN_DONE];
  // edges found on the synchronised copy; data shares its latency
  assign cclk_rise = pins[pscp_pkg::PIN_CCLK] & ~cclk_prev;
  assign cclk_fall = ~pins[pscp_pkg::PIN_CCLK] & cclk_prev;

  function automatic logic [pscp_pkg::CNT_W-1:0] inc(
    input logic [pscp_pkg::CNT_W-1:0] v
  );
    inc = v + pscp_pkg::CNT_ONE;
  endfunction

  always_comb
  begin
    next_state          = state;
    next_timer          = timer;
    next_bits           = bits;
    next_shreg          = shreg;
    next_bit_pos        = bit_pos;
    next_falls          = falls;
    next_cfg_byte       = o_cfg_byte;
    next_cfg_byte_valid = 1'b0;
    case (state)
      pscp_pkg::PSCP_POR:
      begin
        next_timer = inc(timer);
        if (inc(timer) >= POR_CYCLES)
        begin
          next_timer = '0;
          next_state = req_n ? pscp_pkg::PSCP_HOLD
                             : pscp_pkg::PSCP_RESET;
        end
      end
      pscp_pkg::PSCP_RESET:
      begin
        if (req_n)
          next_state = pscp_pkg::PSCP_HOLD;
      end
      pscp_pkg::PSCP_HOLD:
      begin
        next_bits    = '0;
        next_bit_pos = '0;
        next_falls   = '0;
        // another device may still hold the shared line low
        if (status_hi)
          next_state = pscp_pkg::PSCP_LOAD;
      end
      pscp_pkg::PSCP_LOAD:
      begin
        if (i_cfg_error)
        begin
          next_timer = '0;
          next_state = pscp_pkg::PSCP_ERROR;
        end
        else if (!status_hi)
          next_state = pscp_pkg::PSCP_HOLD;
        else if (cclk_rise)
        begin
          // lsb arrives first, so shift toward bit 0
          next_shreg   = {pins[pscp_pkg::PIN_DATA], shreg[7:1]};
          next_bits    = inc(bits);
          next_bit_pos = bit_pos + 3'h1;
          if (bit_pos == pscp_pkg::BYTE_LAST_BIT)
          begin
            next_cfg_byte       = {pins[pscp_pkg::PIN_DATA], shreg[7:1]};
            next_cfg_byte_valid = 1'b1;
          end
          if (inc(bits) >= STREAM_LEN)
            next_state = pscp_pkg::PSCP_DONE_WAIT;
        end
      end
      pscp_pkg::PSCP_ERROR:
      begin
        // without auto restart only the request pin gets out of here
        if (pins[pscp_pkg::PIN_AUTO])
        begin
          next_timer = inc(timer);
          if (inc(timer) >= RESTART_CYCLES)
          begin
            next_timer = '0;
            next_state = pscp_pkg::PSCP_HOLD;
          end
        end
      end
      pscp_pkg::PSCP_DONE_WAIT:
      begin
        if (!status_hi)
          next_state = pscp_pkg::PSCP_HOLD;
        else if (done_hi && cclk_fall)
        begin
          next_falls = falls + 2'h1;
          if (falls + 2'h1 == pscp_pkg::DONE_FALLS)
          begin
            next_timer = '0;
            next_state = pscp_pkg::PSCP_INIT;
          end
        end
      end
      pscp_pkg::PSCP_INIT:
      begin
        next_timer = inc(timer);
        if (inc(timer) >= INIT_CYCLES)
          next_state = pscp_pkg::PSCP_USER;
      end
      pscp_pkg::PSCP_USER:
      begin
        next_state = pscp_pkg::PSCP_USER;
      end
      default:
      begin
        next_state = pscp_pkg::PSCP_POR;
      end
    endcase
    // a low request restarts from anywhere once power-on reset is over
    if (!req_n && state != pscp_pkg::PSCP_POR)
    begin
      next_state = pscp_pkg::PSCP_RESET;
      next_timer = '0;
    end
  end

  always_comb
  begin
    next_status_oe = (next_state == pscp_pkg::PSCP_POR) ||
                     (next_state == pscp_pkg::PSCP_RESET) ||
                     (next_state == pscp_pkg::PSCP_ERROR);
    next_done_oe   = (next_state != pscp_pkg::PSCP_DONE_WAIT) &&
                     (next_state != pscp_pkg::PSCP_INIT) &&
                     (next_state != pscp_pkg::PSCP_USER);
    next_user_mode = (next_state == pscp_pkg::PSCP_USER);
    next_init_oe   = !next_user_mode;
    next_data_oe   = next_user_mode && pins[pscp_pkg::PIN_DUAL];
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state            <= pscp_pkg::PSCP_POR;
      timer            <= '0;
      bits             <= '0;
      shreg            <= '0;
      bit_pos          <= '0;
      falls            <= '0;
      cclk_prev        <= 1'b0;
      o_cfg_byte       <= '0;
      o_cfg_byte_valid <= 1'b0;
      o_status_oe      <= 1'b1;
      o_done_oe        <= 1'b1;
      o_init_oe        <= 1'b1;
      o_data_oe        <= 1'b0;
      o_data_out       <= 1'b0;
      o_user_mode      <= 1'b0;
      o_weak_pullup_en <= 1'b1;
    end
    else
    begin
      state            <= next_state;
      timer            <= next_timer;
      bits             <= next_bits;
      shreg            <= next_shreg;
      bit_pos          <= next_bit_pos;
      falls            <= next_falls;
      cclk_prev        <= pins[pscp_pkg::PIN_CCLK];
      o_cfg_byte       <= next_cfg_byte;
      o_cfg_byte_valid <= next_cfg_byte_valid;
      o_status_oe      <= next_status_oe;
      o_done_oe        <= next_done_oe;
      o_init_oe        <= next_init_oe;
      o_data_oe        <= next_data_oe;
      o_data_out       <= i_user_data_out;
      o_user_mode      <= next_user_mode;
      o_weak_pullup_en <= !next_user_mode;
    end
  end

  // open-drain lines only ever pull low
  assign o_status_out = 1'b0;
  assign o_done_out   = 1'b0;
  assign o_init_out   = 1'b0;
endmodule

// file: pscp_port_props.sv
// checker on the pins of the serial configuration port
// assumes sim sized restart count handed on by the bind
`timescale 1ns/1ps
module pscp_port_props #(
  parameter logic [31:0] RESTART_CYCLES = 32'h0000_0010
) (
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  input  wire logic i_cfg_request_n,
  input  wire logic i_status_in,
  input  wire logic i_auto_restart,
  input  wire logic i_cfg_error,
  input  wire logic o_status_oe,
  input  wire logic o_done_oe,
  input  wire logic o_init_oe,
  input  wire logic o_data_oe,
  input  wire logic o_cfg_byte_valid,
  input  wire logic o_weak_pullup_en,
  input  wire logic o_user_mode
);
  logic        load_err;
  logic [31:0] err_cnt;
  logic [31:0] next_err_cnt;
  assign load_err = i_cfg_error && !o_status_oe && o_done_oe && i_status_in;
  // first cycles tolerated while the pull-down is still launching
  always_comb
  begin
    next_err_cnt = 32'h0000_0000;
    if (load_err)
      next_err_cnt = 32'h0000_0001;
    else if (err_cnt != 0 && (o_status_oe || err_cnt < 32'h0000_0008))
      next_err_cnt = err_cnt + 32'h0000_0001;
  end
  always_ff @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
      err_cnt <= 32'h0000_0000;
    else
      err_cnt <= next_err_cnt;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  sequence por_hold;
    o_status_oe [*8];
  endsequence
  sequence quiet8;
    !o_cfg_byte_valid [*8];
  endsequence
  por_status_a: assert property ($rose(i_arst_n) |-> por_hold)
    else $error("status released right after reset");
  err_status_a: assert property (load_err |-> ##[1:4] o_status_oe)
    else $error("status not pulled low on error");
  restart_tmo_a: assert property (i_auto_restart
    |-> err_cnt <= RESTART_CYCLES + 32'h0000_0008)
    else $error("status held too long after error");
  done_rise_a: assert property ($fell(o_done_oe)
    |-> o_cfg_byte_valid && !o_status_oe)
    else $error("load-complete released off a byte end");
  req_reset_a: assert property ($fell(i_cfg_request_n)
    |-> ##[1:6] (o_status_oe && o_done_oe))
    else $error("request low did not reset the port");
  user_entry_a: assert property ($rose(o_user_mode)
    |-> !o_init_oe && !o_weak_pullup_en)
    else $error("user mode entered with init or pull-ups held");
  data_oe_a: assert property (o_data_oe |-> o_user_mode)
    else $error("data pin driven outside user mode");
  valid_pulse_a: assert property (o_cfg_byte_valid |=> quiet8)
    else $error("byte strobe too long or too close");
endmodule
bind pscp_port pscp_port_props #(.RESTART_CYCLES(RESTART_CYCLES))
  pscp_port_props_inst (.i_mclk, .i_arst_n, .i_cfg_request_n, .i_status_in,
  .i_auto_restart, .i_cfg_error, .o_status_oe, .o_done_oe, .o_init_oe,
  .o_data_oe, .o_cfg_byte_valid, .o_weak_pullup_en, .o_user_mode);

// file: pscp_sync.sv
// two-stage synchroniser for a vector of unrelated pin levels
// assumes each bit is a slow level; no bus coherence across bits
`timescale 1ns/1ps
module pscp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta   <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// file: tb.sv
// bench for the serial configuration port driven by the host model
// assumes sim sized counts; wires pulled up unless someone pulls low
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] INIT_N = 32'h0000_0010;
  localparam logic [7:0]  BS [4] = '{8'h02, 8'h1B, 8'hEE, 8'h01};
  logic mclk, arst_n, err, autor, dual, udata, req_n, cclk, data, dw;
  logic st_oe, dn_oe, in_oe, d_oe, d_out, v, pu, um;
  logic [7:0] cb;
  logic [7:0] got [$];
  int mismatches, compares, cyc;
  wire st_w = !st_oe;
  wire dn_w = !dn_oe;
  assign dw = d_oe ? d_out : data;
  pscp_port #(.POR_CYCLES(32'h0000_0014), .RESTART_CYCLES(32'h0000_0010),
    .INIT_CYCLES(INIT_N), .STREAM_LEN(32'h0000_0020)) pscp_port_inst (
    .i_mclk(mclk), .i_arst_n(arst_n), .i_cfg_request_n(req_n),
    .i_config_clock(cclk), .i_data_in(dw), .i_status_in(st_w),
    .i_done_in(dn_w), .i_auto_restart(autor), .i_dual_purpose(dual),
    .i_cfg_error(err), .i_user_data_out(udata), .o_status_out(),
    .o_status_oe(st_oe), .o_done_out(), .o_done_oe(dn_oe), .o_init_out(),
    .o_init_oe(in_oe), .o_data_out(d_out), .o_data_oe(d_oe),
    .o_cfg_byte(cb), .o_cfg_byte_valid(v), .o_weak_pullup_en(pu),
    .o_user_mode(um));
  pscp_host pscp_host_inst (.i_status(st_w), .i_done(dn_w),
    .o_req_n(req_n), .o_cclk(cclk), .o_data(data));
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  task automatic chk(input logic a, input logic e, input string m);
    compares++;
    if (a !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // strobe sampled on the quiet edge, after the register update
  always @(negedge mclk)
  begin
    if (v === 1'b1)
      got.push_back(cb);
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      $display("unexpected at %0t: run hung", $time);
      close_out();
    end
  end
  task automatic t_power();
    repeat (10) @(negedge mclk);
    chk(st_oe, 1'b1, "status released early");
    pscp_host_inst.wait_ready();
    chk(st_w, 1'b1, "status never released");
    chk(dn_oe, 1'b1, "load-complete not held");
    $display("test power done");
  endtask
  task automatic load(input logic dl);
    @(negedge mclk) dual = dl;
    got.delete();
    for (int i = 0; i < 4; i++)
    begin
      chk(dn_oe, 1'b1, "load-complete early");
      pscp_host_inst.send_byte(BS[i], i == 2 ? 200 : 0);
    end
    repeat (8) @(negedge mclk);
    chk(dn_oe, 1'b0, "load-complete held");
    chk(got.size() == 4, 1'b1, "byte count");
    foreach (got[i]) chk(got[i] === BS[i], 1'b1, "byte value");
    pscp_host_inst.clk(1);
    repeat (INIT_N + 8) @(negedge mclk);
    chk(um, 1'b0, "user mode on one edge");
    pscp_host_inst.clk(1);
    repeat (INIT_N + 8) @(negedge mclk);
    chk(um, 1'b1, "no user mode");
    chk(in_oe, 1'b0, "init-complete held");
    chk(pu, 1'b0, "pull-ups kept");
    chk(d_oe, dl, "data pin drive");
    if (dl)
      chk(dw, udata, "data pin level");
    $display("test load done");
  endtask
  task automatic t_error(input logic ar);
    @(negedge mclk) autor = ar;
    pscp_host_inst.pulse_req();
    pscp_host_inst.wait_ready();
    pscp_host_inst.send_byte(8'hA5, 0);
    @(negedge mclk) err = 1'b1;
    @(negedge mclk) err = 1'b0;
    repeat (4) @(negedge mclk);
    chk(st_oe, 1'b1, "no pull on error");
    repeat (24) @(negedge mclk);
    chk(st_oe, !ar, "restart release");
    if (!ar)
      pscp_host_inst.pulse_req();
    pscp_host_inst.wait_ready();
    load(ar);
    $display("test error done");
  endtask
  initial
  begin
    arst_n = 1'b0;
    err    = 1'b0;
    autor  = 1'b1;
    dual   = 1'b0;
    udata  = 1'b1;
    repeat (4) @(negedge mclk);
    arst_n = 1'b1;
    t_power();
    load(1'b0);
    t_error(1'b1);
    t_error(1'b0);
    close_out();
  end
endmodule
